//--- shared/rxf_pkg.sv
`default_nettype none
package rxf_pkg;
  // Bus map
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] CTRL_OFS = 12'h048;
  localparam logic [11:0] DATA_OFS = 12'h04c;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Bits 18..10 never store
  localparam logic [31:0] CTRL_WMASK = 32'hfff8_03ff;
  // Control fields
  localparam int unsigned BIT_EN = 31;
  localparam int unsigned BIT_AAB = 30;
  localparam int unsigned BIT_AAM = 29;
  localparam int unsigned BIT_AAU = 28;
  localparam int unsigned BIT_APM = 27;
  localparam int unsigned PAT_HI = 26;
  localparam int unsigned PAT_LO = 23;
  localparam int unsigned BIT_ARP = 22;
  localparam int unsigned BIT_MULTICAST_HASH_ENABLE = 21;
  localparam int unsigned BIT_UNICAST_HASH_ENABLE = 20;
  localparam int unsigned BIT_ULM = 19;
  localparam int unsigned IADDR_W = 10;
  // Internal filter addresses
  localparam logic [9:0] IA_PM0 = 10'h000;
  localparam logic [9:0] IA_PM1 = 10'h002;
  localparam logic [9:0] IA_PM2 = 10'h004;
  localparam logic [9:0] IA_CNT01 = 10'h006;
  localparam logic [9:0] IA_CNT23 = 10'h008;
  localparam logic [9:0] IA_PW0 = 10'h00a;
  localparam logic [9:0] IA_PW1 = 10'h00c;
  localparam logic [9:0] IA_PW2 = 10'h00e;
  localparam int unsigned IA_MEM_BIT = 9;
  // Filter memory, one entry per even address
  localparam int unsigned MEM_DEPTH = 256;
  localparam int unsigned PAT_N = 4;
  localparam logic [7:0] HASH_BASE = 8'h00;
  localparam logic [3:0][7:0] PAT_BASE = {8'h81, 8'h80, 8'h41, 8'h40};
  localparam int unsigned MASK_LO = 16;
  // Frame fields
  localparam logic [15:0] ARP_TYPE = 16'h0806;
  localparam logic [7:0] PATTERN_COUNT_MIN = 8'h02;
  localparam logic [7:0] DA_BYTES = 8'h06;
  localparam logic [7:0] TYPE_HI_POS = 8'h0c;
  localparam logic [7:0] TYPE_LO_POS = 8'h0d;
  localparam logic [7:0] POS_MAX = 8'hff;
  localparam logic [47:0] BCAST_DA = 48'hffff_ffff_ffff;
  localparam logic [47:0] UL_MASK = 48'h0000_0000_0002;
  localparam int unsigned MCAST_BIT = 0;
  typedef logic [17:0] rxf_word_t;
endpackage : rxf_pkg
`default_nettype wire

//--- shared/rxf_mem_if.sv
`timescale 1ns/10ps
`default_nettype none
interface rxf_mem_if;
  import rxf_pkg::*;
  logic sw_we; // Software write strobe
  logic [7:0] sw_idx; // Software entry index
  rxf_word_t sw_wdata;
  rxf_word_t sw_rdata;
  logic [5:0] pat_sel; // Word within each pattern
  rxf_word_t pat_word [PAT_N];
  logic [4:0] hash_sel; // Hash word index
  logic [15:0] hash_word;
  modport ctl (output sw_we, sw_idx, sw_wdata, pat_sel, hash_sel,
               input sw_rdata, pat_word, hash_word);
  modport mem (input sw_we, sw_idx, sw_wdata, pat_sel, hash_sel,
               output sw_rdata, pat_word, hash_word);
endinterface : rxf_mem_if
`default_nettype wire

//--- hw/rxf_mem.sv
`timescale 1ns/10ps
`default_nettype none
module rxf_mem (
  input wire logic pclk,
  input wire logic presetn,
  rxf_mem_if.mem mif
);
  import rxf_pkg::*;

  rxf_word_t store_q [MEM_DEPTH]; // Hash table and pattern words

  // Cleared at reset so lookups never see unknowns
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        store_q[i] <= '0;
      end
    end else if (mif.sw_we) begin
      store_q[mif.sw_idx] <= mif.sw_wdata;
    end
  end

  assign mif.sw_rdata = store_q[mif.sw_idx];
  assign mif.hash_word = store_q[8'(HASH_BASE + 8'(mif.hash_sel))][15:0];

  // One lookup per pattern; words of a pair interleave
  genvar p;
  generate
    for (p = 0; p < PAT_N; p++) begin : g_pat
      assign mif.pat_word[p] =
        store_q[8'(PAT_BASE[p] + 8'({mif.pat_sel, 1'b0}))];
    end
  endgenerate
endmodule : rxf_mem
`default_nettype wire

//--- hw/rxf_match.sv
`timescale 1ns/10ps
`default_nettype none
module rxf_match (
  input wire logic [31:0] cfg,
  input wire logic [47:0] da,
  input wire logic [15:0] etype,
  input wire logic [47:0] pm,
  input wire logic hash_hit,
  input wire logic node_hit,
  input wire logic [3:0] pat_hit,
  output logic accept
);
  import rxf_pkg::*;

  logic bcast, mcast, ucast, pm_hit, arp_ok, other_ok;
  logic [47:0] cmp_mask; // Perfect match compare mask

  assign bcast = (da == BCAST_DA);
  assign mcast = da[MCAST_BIT] & ~bcast;
  assign ucast = ~da[MCAST_BIT];
  // U/L bit dropped from compare when asked
  assign cmp_mask = cfg[BIT_ULM] ? ~UL_MASK : BCAST_DA;
  assign pm_hit = cfg[BIT_APM] & (((da ^ pm) & cmp_mask) == '0);
  // ARP only bypasses when enabled
  assign arp_ok = cfg[BIT_ARP] & (etype == ARP_TYPE);

  // Any enabled criterion accepts a non-broadcast frame
  always_comb begin
    other_ok = pm_hit | (|(pat_hit & cfg[PAT_HI:PAT_LO]));
    if (mcast) begin
      other_ok = other_ok | cfg[BIT_AAM] | (cfg[BIT_MULTICAST_HASH_ENABLE] & hash_hit);
    end
    if (ucast) begin
      other_ok = other_ok | cfg[BIT_AAU] | node_hit
                 | (cfg[BIT_UNICAST_HASH_ENABLE] & hash_hit);
    end
    // Broadcast only by its own bit or ARP
    if (bcast) begin
      other_ok = cfg[BIT_AAB];
    end
    accept = cfg[BIT_EN] & (other_ok | arp_ok);
  end
endmodule : rxf_match
`default_nettype wire

//--- hw/rxf_top.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Enable bit filters; clear rejects everything
// - Broadcast accepted only by its own bit or ARP
// - All multicast, else hash decides multicast
// - All unicast, else node address match
// - Perfect match value used only when enabled
// - Pattern bits accept first n matching bytes
// - ARP bit accepts type 0806 frames
// - ARP bit clear gives no special case
// - Multicast hash hit accepts when enabled
// - Unicast hash hit accepts when enabled
// - Mask bit hides U/L bit in match
// - Low ten bits select internal location
// - Perfect match pairs at 000,002,004
// - Pattern counts at 006 and 008
// - Wake password pairs at 00A,00C,00E
// - 200 to 3FE reach filter memory
// - Data port reads/writes the selected location
// - Hash index is low nine CRC bits
module rxf_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic soft_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rxf_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic [8:0] rx_da_crc,
  input wire logic rx_node_hit,
  output logic rx_accept,
  output logic rx_reject
);
  import rxf_pkg::*;

  rxf_mem_if mif ();

  // Filter memory, flop based
  rxf_mem u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .mif(mif)
  );

  logic [31:0] ctrl_q; // Control register
  logic [15:0] pm_q [3]; // Perfect match octet pairs
  logic [15:0] cnt_q [2]; // Pattern counts, two per word
  logic [15:0] pw_q [3]; // Wake password octet pairs
  logic [9:0] iaddr; // Indirect address field
  logic hit_ctrl, hit_data; // Bus decode
  logic setup, wr_fire; // Bus phases
  logic [17:0] int_rdata; // Selected internal data
  logic int_known; // Internal address is mapped
  logic [31:0] prdata_q;
  logic pslverr_q;

  // Selection comes straight from the control word
  assign iaddr = ctrl_q[IADDR_W-1:0];
  assign setup = psel & ~penable;
  assign wr_fire = psel & penable & pwrite;

  // Bus decode on the full word address
  always_comb begin
    hit_ctrl = 1'b0;
    hit_data = 1'b0;
    if (paddr == CTRL_OFS) begin
      hit_ctrl = 1'b1;
    end else if (paddr == DATA_OFS) begin
      hit_data = 1'b1;
    end
  end

  // Internal location mux behind the data port
  always_comb begin
    int_rdata = '0;
    int_known = 1'b1;
    if (iaddr[IA_MEM_BIT]) begin
      int_rdata = mif.sw_rdata;
    end else if (iaddr == IA_PM0) begin
      int_rdata = {2'b00, pm_q[0]};
    end else if (iaddr == IA_PM1) begin
      int_rdata = {2'b00, pm_q[1]};
    end else if (iaddr == IA_PM2) begin
      int_rdata = {2'b00, pm_q[2]};
    end else if (iaddr == IA_CNT01) begin
      int_rdata = {2'b00, cnt_q[0]};
    end else if (iaddr == IA_CNT23) begin
      int_rdata = {2'b00, cnt_q[1]};
    end else if (iaddr == IA_PW0) begin
      int_rdata = {2'b00, pw_q[0]};
    end else if (iaddr == IA_PW1) begin
      int_rdata = {2'b00, pw_q[1]};
    end else if (iaddr == IA_PW2) begin
      int_rdata = {2'b00, pw_q[2]};
    end else begin
      int_known = 1'b0;
    end
  end

  // Zero wait states; read data is caught in setup
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q & psel & penable;

  // Read data and error flag, taken at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pslverr_q <= ~(hit_ctrl | (hit_data & int_known));
      if (pwrite) begin
        prdata_q <= '0;
      end else if (hit_ctrl) begin
        prdata_q <= ctrl_q & CTRL_WMASK;
      end else if (hit_data) begin
        prdata_q <= {14'h0000, int_rdata};
      end else begin
        prdata_q <= '0;
      end
    end
  end

  // Control register; soft reset clears it too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (soft_rst) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_fire & hit_ctrl) begin
      // Unused bits never store
      ctrl_q <= pwdata & CTRL_WMASK;
    end
  end

  // Internal registers written through the data port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) begin
        pm_q[i] <= '0;
        pw_q[i] <= '0;
      end
      cnt_q[0] <= '0;
      cnt_q[1] <= '0;
    end else if (wr_fire & hit_data & ~iaddr[IA_MEM_BIT]) begin
      if (iaddr == IA_PM0) begin
        pm_q[0] <= pwdata[15:0];
      end else if (iaddr == IA_PM1) begin
        pm_q[1] <= pwdata[15:0];
      end else if (iaddr == IA_PM2) begin
        pm_q[2] <= pwdata[15:0];
      end else if (iaddr == IA_CNT01) begin
        cnt_q[0] <= pwdata[15:0];
      end else if (iaddr == IA_CNT23) begin
        cnt_q[1] <= pwdata[15:0];
      end else if (iaddr == IA_PW0) begin
        pw_q[0] <= pwdata[15:0];
      end else if (iaddr == IA_PW1) begin
        pw_q[1] <= pwdata[15:0];
      end else if (iaddr == IA_PW2) begin
        pw_q[2] <= pwdata[15:0];
      end
    end
  end

  // Memory port; odd addresses fold onto the even word
  assign mif.sw_we = wr_fire & hit_data & iaddr[IA_MEM_BIT];
  assign mif.sw_idx = iaddr[8:1];
  assign mif.sw_wdata = pwdata[17:0];

  // Frame side state
  logic [7:0] pos_q; // Byte index within frame
  logic [7:0] len_q; // Length of the finished frame
  logic [7:0] da_b_q [6]; // Destination octets
  logic [15:0] type_q; // Type/length field
  logic [3:0] pat_ok_q; // Pattern still matching
  logic [3:0] pat_hit; // Pattern matched in full
  logic [8:0] crc_q; // Destination CRC of last frame
  logic node_q; // Node address hit of last frame
  logic done_q; // Frame ended last cycle
  logic [47:0] da_w;
  logic [47:0] pm_w;
  logic accept;
  logic acc_q, rej_q;
  logic eof;

  assign eof = rx_valid & rx_last;
  assign da_w = {da_b_q[5], da_b_q[4], da_b_q[3],
                 da_b_q[2], da_b_q[1], da_b_q[0]};
  assign pm_w = {pm_q[2], pm_q[1], pm_q[0]};

  // Byte position; saturates on long frames
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_q <= '0;
    end else if (rx_valid) begin
      if (rx_last) begin
        pos_q <= '0;
      end else if (pos_q != POS_MAX) begin
        pos_q <= pos_q + 8'h01;
      end
    end
  end

  // Header capture: address octets and type field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 6; i++) begin
        da_b_q[i] <= '0;
      end
      type_q <= '0;
    end else if (rx_valid) begin
      if (pos_q < DA_BYTES) begin
        da_b_q[pos_q[2:0]] <= rx_data;
      end
      // A short frame must not keep the old type
      if (pos_q == '0) begin
        type_q <= '0;
      end else if (pos_q == TYPE_HI_POS) begin
        type_q[15:8] <= rx_data;
      end else if (pos_q == TYPE_LO_POS) begin
        type_q[7:0] <= rx_data;
      end
    end
  end

  // Frame end captures; crc and node hit are valid on the last byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
      crc_q <= '0;
      node_q <= 1'b0;
      len_q <= '0;
    end else begin
      done_q <= eof;
      if (eof) begin
        crc_q <= rx_da_crc;
        node_q <= rx_node_hit;
        len_q <= (pos_q == POS_MAX) ? POS_MAX : pos_q + 8'h01;
      end
    end
  end

  // Pattern compare, one byte per beat on all four buffers
  assign mif.pat_sel = pos_q[6:1];
  genvar p;
  generate
    for (p = 0; p < PAT_N; p++) begin : g_pat
      logic [7:0] cnt; // Bytes to compare
      logic [7:0] ref_b; // Stored byte
      logic masked; // Byte is a don't care
      logic byte_ok;
      assign cnt = cnt_q[p / 2][8 * (p % 2) +: 8];
      assign ref_b = pos_q[0] ? mif.pat_word[p][15:8]
                              : mif.pat_word[p][7:0];
      assign masked = mif.pat_word[p][MASK_LO + 32'(pos_q[0])];
      assign byte_ok = masked | (ref_b == rx_data) | (pos_q >= cnt);
      // Running match over the first n bytes
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pat_ok_q[p] <= 1'b0;
        end else if (rx_valid) begin
          pat_ok_q[p] <= ((pos_q == '0) | pat_ok_q[p]) & byte_ok;
        end
      end
      // Short frames and too small counts never hit
      assign pat_hit[p] = pat_ok_q[p] & (cnt >= PATTERN_COUNT_MIN)
                          & (len_q >= cnt);
    end
  endgenerate

  // Hash word by crc[8:4], bit by crc[3:0]
  assign mif.hash_sel = crc_q[8:4];

  // Acceptance decision
  rxf_match u_match (
    .cfg(ctrl_q),
    .da(da_w),
    .etype(type_q),
    .pm(pm_w),
    .hash_hit(mif.hash_word[crc_q[3:0]]),
    .node_hit(node_q),
    .pat_hit(pat_hit),
    .accept(accept)
  );

  // One verdict pulse per frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= 1'b0;
      rej_q <= 1'b0;
    end else begin
      acc_q <= done_q & accept;
      rej_q <= done_q & ~accept;
    end
  end

  assign rx_accept = acc_q;
  assign rx_reject = rej_q;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_end;
    rx_valid && rx_last;
  endsequence

  sequence s_dwr(logic [9:0] a);
    psel && penable && pwrite && paddr == DATA_OFS && iaddr == a
      && !soft_rst;
  endsequence

  chk_off_rejects: assert property (
    s_end ##1 !ctrl_q[BIT_EN] |=> rx_reject && !rx_accept)
    else $error("Disabled filter accepted a frame");

  chk_bcast_taken: assert property (
    s_end ##1 (ctrl_q[BIT_EN] && ctrl_q[BIT_AAB] && da_w == BCAST_DA)
      |=> rx_accept)
    else $error("Broadcast not accepted");

  chk_bcast_block: assert property (
    s_end ##1 (!ctrl_q[BIT_AAB] && !ctrl_q[BIT_ARP]
      && da_w == BCAST_DA) |=> rx_reject)
    else $error("Broadcast accepted without enable");

  // Broadcast also has the group bit set, but is governed by its own bit
  chk_mcast_all: assert property (
    s_end ##1 (ctrl_q[BIT_EN] && ctrl_q[BIT_AAM] && da_w[MCAST_BIT]
      && da_w != BCAST_DA) |=> rx_accept)
    else $error("Multicast not accepted");

  chk_ucast_all: assert property (
    s_end ##1 (ctrl_q[BIT_EN] && ctrl_q[BIT_AAU] && !da_w[0])
      |=> rx_accept)
    else $error("Unicast not accepted");

  chk_arp_any: assert property (
    s_end ##1 (ctrl_q[BIT_EN] && ctrl_q[BIT_ARP]
      && type_q == ARP_TYPE) |=> rx_accept)
    else $error("ARP frame not accepted");

  chk_pm_store: assert property (
    s_dwr(IA_PM1) |=> pm_q[1] == $past(pwdata[15:0]))
    else $error("Perfect match pair not written");

  chk_cnt_store: assert property (
    s_dwr(IA_CNT23) |=> cnt_q[1] == $past(pwdata[15:0]))
    else $error("Pattern count not written");

  chk_ctrl_zero: assert property (
    psel && penable && pwrite && paddr == CTRL_OFS && !soft_rst
      |=> ctrl_q[18:10] == '0 && ctrl_q[31:19] == $past(pwdata[31:19]))
    else $error("Control write stored wrongly");

  chk_mem_rdback: assert property (
    psel && penable && pwrite && paddr == DATA_OFS && iaddr[IA_MEM_BIT]
      && !soft_rst |=> mif.sw_rdata == $past(pwdata[17:0]))
    else $error("Filter memory write lost");

  chk_pw_read: assert property (
    setup && !pwrite && paddr == DATA_OFS && iaddr == IA_PW0
      |=> prdata == {16'h0000, $past(pw_q[0])})
    else $error("Password pair read wrong");
endmodule : rxf_top
`default_nettype wire

//--- testbench/rxf_frame_src.sv
`timescale 1ns/10ps
`default_nettype none
// Receive datapath stand-in: hands frame bytes to the filter
module rxf_frame_src (
  input wire logic pclk,
  output var logic rx_valid,
  output var logic [7:0] rx_data,
  output var logic rx_last,
  output var logic [8:0] rx_da_crc,
  output var logic rx_node_hit
);
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h5a;
    rx_last = 1'b0;
    rx_da_crc = 9'h000;
    rx_node_hit = 1'b0;
  end

  logic busy = 1'b0; // Frame in progress; idle toggling stands aside

  // Idle data keeps moving, so a stale byte is never mistaken for valid
  always @(posedge pclk) begin
    if (!rx_valid && !busy) begin
      rx_data <= ~rx_data;
    end
  end

  // One frame: DA, source, type, two payload bytes; gap idles before each
  task automatic send(input logic [47:0] da, input logic [15:0] ty,
                      input logic [8:0] crc, input logic node, input int gap);
    logic [7:0] b;
    busy = 1'b1;
    for (int i = 0; i < 16; i++) begin
      if (i < 6) b = da[8*i+:8];
      else if (i == 12) b = ty[15:8];
      else if (i == 13) b = ty[7:0];
      else b = 8'h30 + 8'(i);
      // Idle beats first, so each byte is offered exactly once
      for (int g = 0; g < gap; g++) begin
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_data <= ~b;
        rx_last <= 1'b0;
      end
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_data <= b;
      rx_last <= (i == 15);
      rx_da_crc <= crc;
      rx_node_hit <= node;
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~b;
    rx_da_crc <= ~crc;
    rx_node_hit <= ~node;
    busy = 1'b0;
  endtask : send
endmodule : rxf_frame_src
`default_nettype wire

//--- testbench/rx_address_filter_control_test.sv
`timescale 1ns/10ps
`default_nettype none
module rx_address_filter_control_test;
  import rxf_pkg::*;
  localparam logic [31:0] F_EN = 32'h1 << BIT_EN;
  localparam logic [31:0] F_AAB = 32'h1 << BIT_AAB;
  localparam logic [31:0] F_AAM = 32'h1 << BIT_AAM;
  localparam logic [31:0] F_AAU = 32'h1 << BIT_AAU;
  localparam logic [31:0] F_APM = 32'h1 << BIT_APM;
  localparam logic [31:0] F_ARP = 32'h1 << BIT_ARP;
  localparam logic [31:0] F_MH = 32'h1 << BIT_MULTICAST_HASH_ENABLE;
  localparam logic [31:0] F_UH = 32'h1 << BIT_UNICAST_HASH_ENABLE;
  localparam logic [31:0] F_ULM = 32'h1 << BIT_ULM;
  localparam logic [47:0] UDA = 48'h5528_0717_0008; // Unicast, octet0 08
  localparam logic [47:0] MDA = 48'h0100_005e_0001; // Multicast
  logic pclk, presetn, soft_rst, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, er;
  logic rx_valid, rx_last, rx_node_hit, rx_accept, rx_reject;
  logic [7:0] rx_data;
  logic [8:0] rx_da_crc;
  int fail_count = 0;
  int checked = 0;

  rxf_top i_rxf_top (.pclk(pclk), .presetn(presetn), .soft_rst(soft_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
    .rx_da_crc(rx_da_crc), .rx_node_hit(rx_node_hit),
    .rx_accept(rx_accept), .rx_reject(rx_reject));
  rxf_frame_src i_rxf_frame_src (.pclk(pclk), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .rx_da_crc(rx_da_crc),
    .rx_node_hit(rx_node_hit));

  // 100 MHz clock
  always #5 pclk = ~pclk;

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  // Single compare for every kind of result
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // APB transfer; waits for pready at a bounded number of edges
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      chk("pready", 32'h1, 32'h0);
      end_of_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Enable is kept low while other bits change
  task automatic cfg(input logic [31:0] v);
    apb(1'b1, CTRL_OFS, v & ~F_EN);
    apb(1'b1, CTRL_OFS, v);
  endtask : cfg

  // Indirect access: select, write through the data port, then read back
  task automatic dp(input logic [9:0] ia, input logic [31:0] wd,
                    input logic [31:0] exp);
    apb(1'b1, CTRL_OFS, {22'h0, ia});
    apb(1'b1, DATA_OFS, wd);
    apb(1'b0, DATA_OFS, 32'h0);
    chk("data port readback", exp, rd);
  endtask : dp

  // Frame through the partner, verdict compared within a few cycles
  task automatic frame(input logic [47:0] da, input logic [15:0] ty,
                       input logic [8:0] crc, input logic node, input int gap,
                       input logic acc);
    int n;
    i_rxf_frame_src.send(da, ty, crc, node, gap);
    for (n = 0; n < 6; n++) begin
      @(posedge pclk);
      if (rx_accept === 1'b1 || rx_reject === 1'b1) break;
    end
    chk("verdict accept,reject", {30'h0, acc, ~acc},
        {30'h0, rx_accept, rx_reject});
    if (n == 6) begin
      end_of_test();
    end
  endtask : frame

  task automatic s_regs;
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("control reset", CTRL_RESET, rd);
    apb(1'b1, CTRL_OFS, 32'h7fff_ffff);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("control unused bits", 32'h7ff8_03ff, rd);
    apb(1'b0, 12'h050, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, er});
    @(posedge pclk);
    soft_rst <= 1'b1;
    @(posedge pclk);
    soft_rst <= 1'b0;
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("control after soft reset", CTRL_RESET, rd);
    apb(1'b1, CTRL_OFS, 32'h0000_0001); // Odd, below memory
    apb(1'b0, DATA_OFS, 32'h0);
    chk("odd internal error", 32'h1, {31'h0, er});
  endtask : s_regs

  task automatic s_internal;
    dp(IA_CNT01, 32'h0000_0002, 32'h0000_0002);
    dp(IA_CNT23, 32'h0000_0406, 32'h0000_0406);
    dp(IA_PW0, 32'h0000_1234, 32'h0000_1234);
    dp(IA_PW2, 32'h0000_beef, 32'h0000_beef);
    dp(10'h3fe, 32'h0003_a5c3, 32'h0003_a5c3);
    dp(IA_PM0, {16'h0, UDA[15:0]}, {16'h0, UDA[15:0]});
    dp(IA_PM1, {16'h0, UDA[31:16]}, {16'h0, UDA[31:16]});
    dp(IA_PM2, {16'h0, UDA[47:32]}, {16'h0, UDA[47:32]});
    dp(10'h280, 32'h0000_4466, 32'h0000_4466);
    dp(10'h234, 32'h0000_0020, 32'h0000_0020);
  endtask : s_internal

  task automatic s_basic;
    cfg(F_AAB | F_AAM | F_AAU);
    frame(BCAST_DA, 16'h0800, 9'h0, 1'b1, 0, 1'b0);
    cfg(F_EN | F_AAB);
    frame(BCAST_DA, 16'h0800, 9'h0, 1'b0, 0, 1'b1);
    cfg(F_EN | F_AAM | F_AAU | F_MH);
    frame(BCAST_DA, 16'h0800, 9'h1a5, 1'b0, 0, 1'b0);
    frame(MDA, 16'h0800, 9'h0, 1'b0, 0, 1'b1);
    frame(48'h1122_3344_5566, 16'h0800, 9'h0, 1'b0, 0, 1'b1);
    cfg(F_EN);
    frame(48'h1122_3344_5566, 16'h0800, 9'h0, 1'b1, 0, 1'b1);
    frame(48'h1122_3344_5566, 16'h0800, 9'h0, 1'b0, 0, 1'b0);
  endtask : s_basic

  task automatic s_match;
    cfg(F_EN | F_APM);
    frame(UDA, 16'h0800, 9'h0, 1'b0, 2, 1'b1);
    frame(UDA ^ UL_MASK, 16'h0800, 9'h0, 1'b0, 0, 1'b0);
    cfg(F_EN | F_APM | F_ULM);
    frame(UDA ^ UL_MASK, 16'h0800, 9'h0, 1'b0, 0, 1'b1);
    cfg(F_EN | F_ULM);
    frame(UDA, 16'h0800, 9'h0, 1'b0, 0, 1'b0);
    cfg(F_EN | (32'h1 << PAT_LO));
    frame(48'h0000_0000_4466, 16'h0800, 9'h0, 1'b0, 1, 1'b1);
    frame(48'h0000_0000_4468, 16'h0800, 9'h0, 1'b0, 0, 1'b0);
    // Masked first byte is a don't care
    dp(10'h280, 32'h0001_4466, 32'h0001_4466);
    cfg(F_EN | (32'h1 << PAT_LO));
    frame(48'h0000_0000_4468, 16'h0800, 9'h0, 1'b0, 0, 1'b1);
  endtask : s_match

  task automatic s_arp_hash;
    cfg(F_EN | F_ARP);
    frame(48'h0a0b_0c0d_0e02, ARP_TYPE, 9'h0, 1'b0, 0, 1'b1);
    frame(48'h0a0b_0c0d_0e02, 16'h0800, 9'h0, 1'b0, 0, 1'b0);
    cfg(F_EN | F_AAB);
    frame(48'h0a0b_0c0d_0e02, ARP_TYPE, 9'h0, 1'b0, 0, 1'b0);
    cfg(F_EN | F_MH);
    frame(MDA, 16'h0800, 9'h1a5, 1'b0, 0, 1'b1);
    frame(MDA, 16'h0800, 9'h1a6, 1'b0, 0, 1'b0);
    frame(UDA, 16'h0800, 9'h1a5, 1'b0, 0, 1'b0);
    cfg(F_EN | F_UH);
    frame(UDA, 16'h0800, 9'h1a5, 1'b0, 0, 1'b1);
    frame(MDA, 16'h0800, 9'h1a5, 1'b0, 0, 1'b0);
    cfg(F_EN);
    frame(MDA, 16'h0800, 9'h1a5, 1'b0, 0, 1'b0);
  endtask : s_arp_hash

  // Reset for 16 cycles, then each scenario in turn
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    soft_rst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    s_regs();
    s_internal();
    s_basic();
    s_match();
    s_arp_hash();
    end_of_test();
  end
endmodule : rx_address_filter_control_test
`default_nettype wire
